// File: tx_confirm_defs.vh
// Constants for the transmit confirmation status encoder
//
// Overview of operation
// - Outcome code is 4 bits, priority encoded, larger code wins.
// - Completed beacon is 0101, completed OK 0110, fatal or internal 1111.
// - Nine error codes 0111 to 1111: confirm, underrun, aborts, timeout, reset, consistency.
// - Two-bit ending frame kind: other, token, foreign void, own void.
// - Full-confirm flag follows whether the request asked for full confirmation.
// - Unexpected-status flag set only in full confirmation when status mismatches expected.
// - Parity flag set on any parity error in a frame received during confirmation.
// - Through-parity mode bit extends parity checking to include the ending delimiter.
// - Any exception sets the exception flag and the channel attention fault bit.
// - Ring-op flag set when ring state changes after transmit, before confirmation ends.
`ifndef TX_CONFIRM_DEFS_VH
`define TX_CONFIRM_DEFS_VH

// Register byte offsets
`define OFS_MODE          8'h00
`define OFS_EXP_STATUS    8'h04
`define OFS_ATTENTION     8'h08
`define OFS_LAST_DESC     8'h0C
`define OFS_CHAN_STATE    8'h10

// Register fields
`define MODE_THRU_PAR_BIT 0
`define ATTN_FAULT_BIT    0
`define EXP_STATUS_W      8

// Reset values
`define RST_MODE          1'b0
`define RST_EXP_STATUS    8'h00
`define RST_ATTENTION     1'b0

// Outcome codes
`define CODE_NONE         4'h0
`define CODE_BEACON       4'h5
`define CODE_OK           4'h6
`define CODE_BAD_CONFIRM  4'h7
`define CODE_UNDERRUN     4'h8
`define CODE_HOST_ABORT   4'h9
`define CODE_BAD_RINGOP   4'hA
`define CODE_CTRL_ABORT   4'hB
`define CODE_TIMEOUT      4'hC
`define CODE_CTRL_RESET   4'hD
`define CODE_CONSIST      4'hE
`define CODE_FATAL        4'hF
`define CODE_FIRST_EXC    4'h7

// Ending frame kinds
`define KIND_OTHER        2'h0
`define KIND_TOKEN        2'h1
`define KIND_OTHER_VOID   2'h2
`define KIND_MY_VOID      2'h3

// Confirmation status bit positions (within the 16-bit status word)
`define CS_KIND_LO        8
`define CS_FULL           10
`define CS_UNEXP          11
`define CS_PARITY         12
`define CS_EXC            13
`define CS_RINGOP         14
`define CS_CLASS          15

// Parity sense of received bytes: 1 for odd
`define PAR_ODD           1'b1

`endif

// File: outcome_priority_encoder.v
// Priority encoder turning a condition vector into the request outcome code
`timescale 1ns/1ps
`default_nettype none

module outcome_priority_encoder (
  input  wire [15:0] cond_i,
  output reg  [3:0]  code_o
);

  integer i;

  // Highest set condition index wins; later loop passes override earlier
  always @* begin
    code_o = 4'h0;
    for (i = 1; i < 16; i = i + 1) begin
      if (cond_i[i]) begin
        code_o = i[3:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: rx_parity_checker.v
// Byte parity checker for frames received during confirmation
`timescale 1ns/1ps
`default_nettype none
`include "tx_confirm_defs.vh"

module rx_parity_checker (
  input  wire       valid_i,
  input  wire [7:0] byte_i,
  input  wire       par_i,
  input  wire       is_delim_i,
  input  wire       thru_i,
  output wire       err_o
);

  wire par_bad;
  wire in_scope;

  // Odd parity: byte and its parity bit together hold an odd count of ones
  assign par_bad  = ((^byte_i) ^ par_i) != `PAR_ODD;
  // The ending delimiter is checked only in through-parity mode
  assign in_scope = valid_i & (~is_delim_i | thru_i);
  assign err_o    = in_scope & par_bad;

endmodule

`default_nettype wire

// File: tx_confirmation_status_encoder.v
// Transmit confirmation status encoder with its APB register file
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tx_confirm_defs.vh"

module tx_confirmation_status_encoder (
  input  wire        clk_i,
  input  wire        arst_n_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // Request channel events
  input  wire        req_start_i,
  input  wire        req_full_i,
  input  wire        req_class_i,
  input  wire        tx_done_i,
  input  wire        req_close_i,
  input  wire [15:0] cond_i,
  // Received frames during confirmation
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        rx_par_i,
  input  wire        rx_is_delim_i,
  input  wire        fs_valid_i,
  input  wire [7:0]  fs_i,
  input  wire        fc_end_i,
  input  wire [1:0]  fc_kind_i,
  input  wire        ring_op_change_i,
  // Descriptor fields
  output reg         desc_valid_o,
  output reg  [3:0]  request_outcome_code_o,
  output reg  [15:0] conf_status_o,
  output wire        request_attention_fault_bit_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------

  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  // Assert at once, release two edges after the pin rises
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------

  reg                     thru_par_q;
  reg [`EXP_STATUS_W-1:0] exp_status_q;
  reg                     attn_fault_q;
  reg [3:0]               last_code_q;
  reg [15:0]              last_cs_q;
  reg                     active_q;
  reg                     tx_done_q;

  wire hit_mode;
  wire hit_exp;
  wire hit_attn;
  wire hit_last;
  wire hit_state;
  wire mapped;
  wire wr_acc;
  wire setup;

  assign hit_mode  = (paddr_i == `OFS_MODE);
  assign hit_exp   = (paddr_i == `OFS_EXP_STATUS);
  assign hit_attn  = (paddr_i == `OFS_ATTENTION);
  assign hit_last  = (paddr_i == `OFS_LAST_DESC);
  assign hit_state = (paddr_i == `OFS_CHAN_STATE);
  assign mapped    = hit_mode | hit_exp | hit_attn | hit_last | hit_state;

  // Zero wait states; read data is loaded in the setup cycle
  assign setup     = psel_i & ~penable_i;
  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Read data is registered so that it stands steady through the access
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      prdata_o <= 32'h0000_0000;
      if (hit_mode) begin
        prdata_o[`MODE_THRU_PAR_BIT] <= thru_par_q;
      end
      if (hit_exp) begin
        prdata_o[`EXP_STATUS_W-1:0] <= exp_status_q;
      end
      if (hit_attn) begin
        prdata_o[`ATTN_FAULT_BIT] <= attn_fault_q;
      end
      if (hit_last) begin
        prdata_o[31:28] <= last_code_q;
        prdata_o[15:0]  <= last_cs_q;
      end
      if (hit_state) begin
        prdata_o[1:0] <= {tx_done_q, active_q};
      end
    end
  end

  // Software-written control
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thru_par_q   <= `RST_MODE;
      exp_status_q <= `RST_EXP_STATUS;
    end else if (wr_acc) begin
      if (hit_mode) begin
        thru_par_q <= pwdata_i[`MODE_THRU_PAR_BIT];
      end
      if (hit_exp) begin
        exp_status_q <= pwdata_i[`EXP_STATUS_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Request accumulation
  // ----------------------------------------------------------------------

  reg        full_q;
  reg        class_q;
  reg [15:0] cond_q;
  reg [1:0]  kind_q;
  reg        unexp_q;
  reg        par_q;
  reg        ringop_q;

  wire        par_err;
  wire        unexp_hit;
  wire        ringop_hit;
  wire [15:0] cond_d;
  wire [1:0]  kind_d;
  wire        unexp_d;
  wire        par_d;
  wire        ringop_d;
  wire [3:0]  code_d;
  wire        exc_d;
  wire [15:0] cs_d;

  rx_parity_checker u_parity (
    .valid_i    (rx_valid_i & active_q),
    .byte_i     (rx_byte_i),
    .par_i      (rx_par_i),
    .is_delim_i (rx_is_delim_i),
    .thru_i     (thru_par_q),
    .err_o      (par_err)
  );

  // Status compare is meaningful only for full confirmation
  assign unexp_hit  = active_q & full_q & fs_valid_i & (fs_i != exp_status_q);
  // Only a change after transmission and before close counts
  assign ringop_hit = active_q & tx_done_q & ring_op_change_i;

  // Events of the closing cycle are folded in so none is lost
  assign cond_d   = cond_q | (active_q ? cond_i : 16'h0000);
  assign kind_d   = (active_q & full_q & fc_end_i) ? fc_kind_i : kind_q;
  assign unexp_d  = unexp_q | unexp_hit;
  assign par_d    = par_q | par_err;
  assign ringop_d = ringop_q | ringop_hit;

  outcome_priority_encoder u_prio (
    .cond_i (cond_d),
    .code_o (code_d)
  );

  // Codes 7 through 15 are the exception and error completions
  assign exc_d = (code_d >= `CODE_FIRST_EXC);

  // Assemble the confirmation status; low byte is the unused field
  assign cs_d[`CS_CLASS]                = class_q;
  assign cs_d[`CS_RINGOP]               = ringop_d;
  assign cs_d[`CS_EXC]                  = exc_d;
  assign cs_d[`CS_PARITY]               = par_d;
  assign cs_d[`CS_UNEXP]                = unexp_d;
  assign cs_d[`CS_FULL]                 = full_q;
  assign cs_d[`CS_KIND_LO+1:`CS_KIND_LO] = kind_d;
  assign cs_d[7:0]                      = 8'h00;

  // Per-request state; a start while active restarts the channel
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      active_q  <= 1'b0;
      tx_done_q <= 1'b0;
      full_q    <= 1'b0;
      class_q   <= 1'b0;
      cond_q    <= 16'h0000;
      kind_q    <= `KIND_OTHER;
      unexp_q   <= 1'b0;
      par_q     <= 1'b0;
      ringop_q  <= 1'b0;
    end else if (req_start_i) begin
      active_q  <= 1'b1;
      tx_done_q <= 1'b0;
      full_q    <= req_full_i;
      class_q   <= req_class_i;
      cond_q    <= 16'h0000;
      kind_q    <= `KIND_OTHER;
      unexp_q   <= 1'b0;
      par_q     <= 1'b0;
      ringop_q  <= 1'b0;
    end else if (req_close_i && active_q) begin
      active_q  <= 1'b0;
      tx_done_q <= 1'b0;
    end else if (active_q) begin
      tx_done_q <= tx_done_q | tx_done_i;
      cond_q    <= cond_d;
      kind_q    <= kind_d;
      unexp_q   <= unexp_d;
      par_q     <= par_d;
      ringop_q  <= ringop_d;
    end
  end

  // ----------------------------------------------------------------------
  // Descriptor output
  // ----------------------------------------------------------------------

  // Fields are held until the next close; valid marks a single cycle
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      desc_valid_o           <= 1'b0;
      request_outcome_code_o <= `CODE_NONE;
      conf_status_o          <= 16'h0000;
      last_code_q            <= `CODE_NONE;
      last_cs_q              <= 16'h0000;
    end else begin
      desc_valid_o <= req_close_i & active_q & ~req_start_i;
      if (req_close_i && active_q && !req_start_i) begin
        request_outcome_code_o <= code_d;
        conf_status_o          <= cs_d;
        last_code_q            <= code_d;
        last_cs_q              <= cs_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Request attention
  // ----------------------------------------------------------------------

  wire attn_set;
  wire attn_clr;

  assign attn_set = req_close_i & active_q & ~req_start_i & exc_d;
  assign attn_clr = wr_acc & hit_attn & pwdata_i[`ATTN_FAULT_BIT];

  // Write one to clear; a new exception in the same cycle wins
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      attn_fault_q <= `RST_ATTENTION;
    end else if (attn_set) begin
      attn_fault_q <= 1'b1;
    end else if (attn_clr) begin
      attn_fault_q <= 1'b0;
    end
  end

  assign request_attention_fault_bit_o = attn_fault_q;

endmodule

`default_nettype wire

// File: tx_confirm_assertions.sv
// Concurrent checks on the transmit confirmation status encoder ports
`timescale 1ns/1ps
`default_nettype none
module tx_confirm_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        req_start_i,
  input wire logic        req_full_i,
  input wire logic        req_class_i,
  input wire logic        req_close_i,
  input wire logic [15:0] cond_i,
  input wire logic        desc_valid_o,
  input wire logic [3:0]  request_outcome_code_o,
  input wire logic [15:0] conf_status_o,
  input wire logic        request_attention_fault_bit_o
);
  logic        act_q;
  logic        full_q;
  logic        cls_q;
  logic [15:0] acc_q;
  logic [3:0]  top_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // -------------------------------------------------
  // Shadow of the request; start-cycle events are not counted
  // -------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_q  <= 1'b0;
      full_q <= 1'b0;
      cls_q  <= 1'b0;
      acc_q  <= 16'h0000;
    end else if (req_start_i) begin
      act_q  <= 1'b1;
      full_q <= req_full_i;
      cls_q  <= req_class_i;
      acc_q  <= 16'h0000;
    end else if (act_q) begin
      act_q <= !req_close_i;
      acc_q <= acc_q | cond_i;
    end
  end
  // Highest pending condition wins
  always_comb begin
    top_d = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (acc_q[i]) top_d = i[3:0];
    end
  end
  chk_pready_high: assert property (psel_i |-> pready_o) else $error("pready low");
  chk_slverr_map: assert property (psel_i && penable_i |-> pslverr_o ==
    !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("pslverr wrong for address");
  chk_close_desc: assert property (act_q && req_close_i && !req_start_i |=> desc_valid_o)
    else $error("no descriptor after close");
  chk_desc_cause: assert property (desc_valid_o |-> $past(act_q && req_close_i && !req_start_i))
    else $error("descriptor without close");
  chk_code_priority: assert property (desc_valid_o |-> request_outcome_code_o == top_d)
    else $error("outcome code not highest condition");
  chk_full_class: assert property (desc_valid_o |-> conf_status_o[10] == full_q
    && conf_status_o[15] == cls_q) else $error("full or class flag wrong");
  chk_full_only: assert property (desc_valid_o && !conf_status_o[10] |-> conf_status_o[11:8] == 4'h0)
    else $error("full-only fields set");
  chk_exc_flag: assert property (desc_valid_o |-> conf_status_o[13] == (request_outcome_code_o >= 4'h7))
    else $error("exception flag wrong");
  chk_exc_attn: assert property (desc_valid_o && conf_status_o[13] |-> request_attention_fault_bit_o)
    else $error("attention bit not set");
  chk_low_zero: assert property (conf_status_o[7:0] == 8'h00) else $error("low byte not zero");
endmodule
bind tx_confirmation_status_encoder tx_confirm_checker u_chk (.clk_i, .arst_n_i, .psel_i,
  .penable_i, .paddr_i, .pready_o, .pslverr_o, .req_start_i, .req_full_i, .req_class_i,
  .req_close_i, .cond_i, .desc_valid_o, .request_outcome_code_o, .conf_status_o,
  .request_attention_fault_bit_o);
`default_nettype wire

// File: host_desc_reader.sv
// Host side model that collects each confirmation descriptor word
`timescale 1ns/1ps
`default_nettype none
module host_desc_reader (
  input wire logic        clk_i,
  input wire logic        desc_valid_o,
  input wire logic [3:0]  request_outcome_code_o,
  input wire logic [15:0] conf_status_o,
  output var logic [31:0] word_o
);
  // Software sees the word as written; the unused low byte is kept as delivered
  initial word_o = 32'h0000_0000;
  always @(posedge clk_i) begin
    if (desc_valid_o) word_o <= {request_outcome_code_o, 12'h000, conf_status_o};
  end
endmodule
`default_nettype wire

// File: tx_confirmation_status_encoder_bench.sv
// Self-checking bench for the transmit confirmation status encoder
`timescale 1ns/1ps
`default_nettype none
module tx_confirmation_status_encoder_bench;
  logic        clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i, rx_byte_i, fs_i, efs;
  logic [31:0] pwdata_i, prdata_o, host_word, rd, wd;
  logic        req_start_i, req_full_i, req_class_i, tx_done_i, req_close_i, er;
  logic [15:0] cond_i, conf_status_o, cv, ecs;
  logic        rx_valid_i, rx_par_i, rx_is_delim_i, fs_valid_i, fc_end_i, ring_op_change_i;
  logic [1:0]  fc_kind_i;
  logic [3:0]  request_outcome_code_o, code;
  logic        desc_valid_o, request_attention_fault_bit_o;
  logic [8:0]  rnd;
  int          n_errors, compares, seed, cyc;
  tx_confirmation_status_encoder uut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .req_start_i, .req_full_i,
    .req_class_i, .tx_done_i, .req_close_i, .cond_i, .rx_valid_i, .rx_byte_i, .rx_par_i,
    .rx_is_delim_i, .fs_valid_i, .fs_i, .fc_end_i, .fc_kind_i, .ring_op_change_i,
    .desc_valid_o, .request_outcome_code_o, .conf_status_o, .request_attention_fault_bit_o);
  host_desc_reader host (.clk_i, .desc_valid_o, .request_outcome_code_o, .conf_status_o,
    .word_o(host_word));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Long enough for every scenario; a hang ends in the report
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One APB transfer; waits for pready rather than assuming zero waits
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic [3:0] top(input logic [15:0] v);
    top = 4'h0;
    for (int i = 0; i < 16; i++) if (v[i]) top = i[3:0];
  endfunction
  // ev: 0 status mismatch, 1 bad delimiter parity, 2 bad data parity, 3 ring change after done
  task automatic req(input logic f, c, input logic [15:0] v, input logic [3:0] ev,
                     input logic [1:0] k);
    @(posedge clk_i);
    req_start_i <= 1'b1;
    req_full_i <= f;
    req_class_i <= c;
    cond_i <= 16'h8000;
    @(posedge clk_i);
    req_start_i <= 1'b0;
    cond_i <= v;
    ring_op_change_i <= 1'b1;
    fs_valid_i <= 1'b1;
    fs_i <= efs ^ {7'h00, ev[0]};
    fc_end_i <= 1'b1;
    fc_kind_i <= k;
    rx_valid_i <= 1'b1;
    rx_byte_i <= rnd[8:1];
    rx_par_i <= ~^rnd[8:1] ^ ev[2];
    @(posedge clk_i);
    {cond_i, ring_op_change_i, fs_valid_i, fc_end_i} <= 19'h00000;
    rx_is_delim_i <= 1'b1;
    rx_par_i <= ~^rnd[8:1] ^ ev[1];
    tx_done_i <= 1'b1;
    @(posedge clk_i);
    {rx_valid_i, rx_is_delim_i, tx_done_i} <= 3'h0;
    ring_op_change_i <= ev[3];
    @(posedge clk_i);
    ring_op_change_i <= 1'b0;
    req_close_i <= 1'b1;
    @(posedge clk_i);
    req_close_i <= 1'b0;
    for (int t = 0; t < 8 && desc_valid_o !== 1'b1; t++) @(negedge clk_i);
    chk("desc_valid", 32'h1, {31'h0, desc_valid_o});
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    seed = 98;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 43'h0;
    {req_start_i, req_full_i, req_class_i, tx_done_i, req_close_i, cond_i} = 21'h0;
    {rx_valid_i, rx_byte_i, rx_par_i, rx_is_delim_i, fs_valid_i, fs_i} = 20'h0;
    {fc_end_i, fc_kind_i, ring_op_change_i} = 4'h0;
    arst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values of every register, then an unmapped place
    for (int a = 0; a <= 8'h14; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk("reg_reset", 32'h0, rd);
      chk("slverr", {31'h0, a == 8'h14}, {31'h0, er});
    end
    // Expected status holds one byte; upper bits read back as zero
    wd = $random(seed);
    efs = wd[7:0];
    apb(1'b1, 8'h04, wd);
    apb(1'b0, 8'h04, 32'h0);
    chk("exp_status", {24'h0, efs}, rd);
    // Every outcome code, random events; conditions outside a request are dropped
    for (int n = 0; n < 36; n++) begin
      cv = (n % 12 == 0) ? 16'h0 : (16'h1 << (n % 12 + 4));
      cv = cv | ((cv - 16'h1) & $random(seed) & 16'hFFE0);
      rnd = $random(seed);
      apb(1'b1, 8'h00, {31'h0, rnd[0]});
      req(rnd[1], rnd[2], cv, rnd[6:3], rnd[8:7]);
      code = top(cv);
      chk("code", {28'h0, code}, {28'h0, request_outcome_code_o});
      ecs = {rnd[2], rnd[6], code >= 4'h7, rnd[5] | (rnd[4] & rnd[0]), rnd[1] & rnd[3],
             rnd[1], rnd[1] ? rnd[8:7] : 2'b00, 8'h00};
      chk("status", {16'h0, ecs}, {16'h0, conf_status_o});
      apb(1'b0, 8'h0C, 32'h0);
      chk("last_desc", {code, 12'h0, ecs}, rd);
      chk("host_word", {code, 12'h0, ecs}, host_word);
      apb(1'b0, 8'h08, 32'h0);
      chk("attention", {31'h0, code >= 4'h7}, rd);
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk("attn_clear", 32'h0, rd);
    end
    // Channel state while a request is open and after it closes
    @(posedge clk_i);
    req_start_i <= 1'b1;
    @(posedge clk_i);
    {req_start_i, tx_done_i} <= 2'b01;
    apb(1'b0, 8'h10, 32'h0);
    chk("chan_busy", 32'h3, rd);
    tx_done_i <= 1'b0;
    req_close_i <= 1'b1;
    @(posedge clk_i);
    req_close_i <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk("chan_idle", 32'h0, rd);
    wrap_up();
  end
endmodule
`default_nettype wire
